// >>> hdl/keypad_menu.sv
// Purpose: Keypad menu editing, multi-function key, run/stop/shift handling
// Assumes: Key inputs synchronous to clk, high while pressed
// Notes: Avalon-MM slave with word addressing and waitrequest
//
// Function
// RULE_01: Enter in edit level commits value, returns to list, selects next parameter.
// RULE_02: Escape in edit level drops the change, returns to list on same parameter.
// RULE_03: Edited value blinks only when writable; steady value means edit refused.
// RULE_04: Stop-only parameters refuse edits while running, accept them when stopped.
// RULE_05: An active user password blocks keypad value changes.
// RULE_06: Action field selects off, channel toggle, reversal, forward jog, reverse jog.
// RULE_07: Action code 0 makes multi-function key presses do nothing.
// RULE_08: Channel toggle with panel run source leaves the channel unchanged.
// RULE_09: Channel toggle with terminal source swaps terminal and panel control.
// RULE_10: Channel toggle with communication source swaps communication and panel control.
// RULE_11: Action 2 inverts frequency direction, only with panel channel active.
// RULE_12: Action 3 commands forward jog, only with panel channel active.
// RULE_13: Action 4 commands reverse jog, only with panel channel active.
// RULE_14: Multi-function key works both stopped and running.
// RULE_15: Run starts acceleration; display shows running frequency until setpoint reached.
// RULE_16: Stop makes the motor decelerate to a halt.
// RULE_17: Shift while running cycles through running monitor selections.
// RULE_18: Run source field: 0 panel, 1 terminal, 2 communication, default 0.
// RULE_19: Shift rotation covers at most five monitor selections.
// RULE_20: Keys are debounced and edge detected, one action per press.
//
// Local design decision: the Avalon-MM interface to the registers.

`timescale 1ns/1ps

module keypad_menu
	import keypad_pkg::*;
#(
	parameter int DEBOUNCE_CYC = DEBOUNCE_CYCLES
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic enterKey,
	input wire logic menuEscapeKey,
	input wire logic upKey,
	input wire logic downKey,
	input wire logic runKey,
	input wire logic stopKey,
	input wire logic shiftKey,
	input wire logic multiKey,
	input wire logic [11:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic motorRun,
	output logic reverseDir,
	output logic forwardJog,
	output logic reverseJog,
	output logic panelActive,
	output logic [15:0] runFrequency,
	output logic [5:0] displayCode,
	output logic [2:0] monitorSlot,
	output logic menuEditing,
	output logic [PARAM_AW-1:0] paramIndex,
	output logic [15:0] editValue,
	output logic valueBlink
);

	typedef struct packed {
		menu_e menu;
		bus_e bus;
		logic [PARAM_AW-1:0] paramIdx;
		logic [15:0] editValue;
		logic editRo;
		logic editStop;
		logic [NUM_KEYS-1:0] samp;
		logic [NUM_KEYS-1:0] keyLevel;
		logic [NUM_KEYS-1:0] keyPrev;
		logic [19:0] debCnt;
		logic [11:0] rampCnt;
		logic [15:0] mkeyAction;
		logic [1:0] runSource;
		logic [15:0] setpoint;
		logic [MONITOR_SLOTS-1:0][5:0] monitor;
		logic password;
		logic panelTaken;
		logic chanPanel;
		logic running;
		logic dirReverse;
		logic jogFwd;
		logic jogRev;
		logic [15:0] runFreq;
		logic [2:0] slot;
		logic [5:0] dispCode;
		logic valueBlink;
		logic editing;
		logic waitreq;
		logic [31:0] readdata;
	} top_s;

	top_s s_q;
	top_s s_d;
	logic [NUM_KEYS-1:0] keyRaw;
	logic [NUM_KEYS-1:0] agree;
	logic [NUM_KEYS-1:0] press;
	logic writable;
	logic [2:0] mkeyCode;
	logic [2:0] monIdx;

	param_mem_if memBus ();

	param_mem u_mem (
		.clk(clk),
		.reset(reset),
		.port(memBus.store)
	);

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	function automatic logic editAllowed(input logic ro, input logic stopOnly,
			input logic run, input logic pw);
		editAllowed = !ro && !(stopOnly && run) && !pw;
	endfunction

	function automatic logic isMonitor(input logic [11:0] a);
		isMonitor = (a >= MONITOR_BASE_IDX) && (a < MONITOR_BASE_IDX + 12'(MONITOR_SLOTS));
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	assign keyRaw = {multiKey, shiftKey, stopKey, runKey, downKey, upKey, menuEscapeKey,
		enterKey};

	always_comb begin
		s_d = s_q;
		agree = ~(s_q.samp ^ keyRaw);
		press = s_q.keyLevel & ~s_q.keyPrev; // RULE_20
		writable = editAllowed(s_q.editRo, s_q.editStop, s_q.running, s_q.password); // RULE_04
		mkeyCode = (s_q.mkeyAction > 16'h0004) ? MKEY_OFF : s_q.mkeyAction[2:0]; // RULE_06
		monIdx = 3'(address - MONITOR_BASE_IDX);
		memBus.en = 1'b0;
		memBus.we = 1'b0;
		memBus.addr = s_q.paramIdx;
		memBus.wdata = {s_q.editRo, s_q.editStop, s_q.editValue};

		// Debounce: a level is taken only after two agreeing samples
		s_d.keyPrev = s_q.keyLevel;
		if (s_q.debCnt == 20'(DEBOUNCE_CYC - 1)) begin
			s_d.debCnt = '0;
			s_d.samp = keyRaw;
			s_d.keyLevel = (agree & keyRaw) | (~agree & s_q.keyLevel); // RULE_20
		end else begin
			s_d.debCnt = s_q.debCnt + 20'h00001;
		end

		// Menu
		unique case (s_q.menu)
			MENU_L2: begin
				if (press[KEY_ENTER]) begin
					memBus.en = 1'b1;
					s_d.menu = MENU_FETCH;
				end else if (press[KEY_UP]) begin
					s_d.paramIdx = s_q.paramIdx + 4'h1;
				end else if (press[KEY_DOWN]) begin
					s_d.paramIdx = s_q.paramIdx - 4'h1;
				end
			end
			MENU_FETCH: begin
				s_d.editValue = memBus.rdata[15:0];
				s_d.editRo = memBus.rdata[PARAM_RO_BIT];
				s_d.editStop = memBus.rdata[PARAM_STOP_BIT];
				s_d.menu = MENU_EDIT;
			end
			MENU_EDIT: begin
				if (press[KEY_ENTER]) begin
					if (writable) begin
						s_d.menu = MENU_COMMIT; // RULE_01
					end else begin
						s_d.menu = MENU_L2;
						s_d.paramIdx = s_q.paramIdx + 4'h1;
					end
				end else if (press[KEY_ESCAPE]) begin
					s_d.menu = MENU_L2; // RULE_02
				end else if (press[KEY_UP] && writable) begin
					s_d.editValue = s_q.editValue + 16'h0001; // RULE_05
				end else if (press[KEY_DOWN] && writable) begin
					s_d.editValue = s_q.editValue - 16'h0001; // RULE_05
				end
			end
			MENU_COMMIT: begin
				memBus.en = 1'b1;
				memBus.we = 1'b1;
				s_d.paramIdx = s_q.paramIdx + 4'h1; // RULE_01
				s_d.menu = MENU_L2;
			end
		endcase

		////////////////////////////////////////////////////////////////////////////////
		// Register bus; the parameter store is shared with the menu, menu first

		unique case (s_q.bus)
			BUS_IDLE: begin
				if (read || write) begin
					if (address[11:4] == PARAM_BASE_IDX[11:4]) begin
						if (!memBus.en) begin
							memBus.en = 1'b1;
							memBus.we = write;
							memBus.addr = address[PARAM_AW-1:0];
							memBus.wdata = writedata[PARAM_W-1:0];
							s_d.bus = BUS_MEM;
						end
					end else begin
						s_d.bus = BUS_DONE;
						s_d.readdata = 32'h00000000;
						if (read) begin
							if (address == MKEY_ACTION_IDX) begin
								s_d.readdata[15:0] = s_q.mkeyAction;
							end else if (address == RUN_SOURCE_IDX) begin
								s_d.readdata[1:0] = s_q.runSource;
							end else if (address == SETPOINT_IDX) begin
								s_d.readdata[15:0] = s_q.setpoint;
							end else if (isMonitor(address)) begin
								s_d.readdata[5:0] = s_q.monitor[monIdx];
							end else if (address == CONTROL_IDX) begin
								s_d.readdata[CTRL_PASSWORD_BIT] = s_q.password;
							end else if (address == STATUS_IDX) begin
								s_d.readdata[15:0] = s_q.runFreq;
								s_d.readdata[STAT_RUNNING_BIT] = s_q.running;
								s_d.readdata[STAT_REVERSE_BIT] = s_q.dirReverse;
								s_d.readdata[STAT_PANEL_BIT] = s_q.chanPanel;
								s_d.readdata[STAT_JOGF_BIT] = s_q.jogFwd;
								s_d.readdata[STAT_JOGR_BIT] = s_q.jogRev;
								s_d.readdata[STAT_EDIT_BIT] = (s_q.menu == MENU_EDIT);
								s_d.readdata[STAT_SLOT_LSB +: 3] = s_q.slot;
							end
						end else begin
							if (address == MKEY_ACTION_IDX) begin
								s_d.mkeyAction = merge16(s_q.mkeyAction, writedata, byteenable);
							end else if (address == RUN_SOURCE_IDX) begin
								if (byteenable[0] && writedata[1:0] != 2'h3) begin
									s_d.runSource = writedata[1:0]; // RULE_18
								end
							end else if (address == SETPOINT_IDX) begin
								s_d.setpoint = merge16(s_q.setpoint, writedata, byteenable);
							end else if (isMonitor(address) && byteenable[0]) begin
								s_d.monitor[monIdx] = writedata[5:0];
							end else if (address == CONTROL_IDX && byteenable[0]) begin
								s_d.password = writedata[CTRL_PASSWORD_BIT];
							end
						end
					end
				end
			end
			BUS_MEM: begin
				s_d.readdata = {14'h0000, memBus.rdata};
				s_d.bus = BUS_DONE;
			end
			BUS_DONE: begin
				s_d.bus = BUS_IDLE;
			end
			default: begin
				s_d.bus = BUS_IDLE;
			end
		endcase
		s_d.waitreq = (s_d.bus != BUS_DONE);

		////////////////////////////////////////////////////////////////////////////////
		// Multi-function key, honoured stopped or running

		if (press[KEY_MULTI]) begin // RULE_14 RULE_07
			if (mkeyCode == MKEY_CHANNEL && s_q.runSource != SRC_PANEL) begin // RULE_08
				s_d.panelTaken = !s_q.panelTaken; // RULE_09 RULE_10
			end else if (mkeyCode == MKEY_DIR && s_q.chanPanel) begin
				s_d.dirReverse = !s_q.dirReverse; // RULE_11
			end
		end
		s_d.jogFwd = (mkeyCode == MKEY_FWD_JOG) && s_q.chanPanel && s_q.keyLevel[KEY_MULTI]; // RULE_12
		s_d.jogRev = (mkeyCode == MKEY_REV_JOG) && s_q.chanPanel && s_q.keyLevel[KEY_MULTI]; // RULE_13
		s_d.chanPanel = (s_d.runSource == SRC_PANEL) || s_d.panelTaken;

		// Run, stop and shift
		if (press[KEY_STOP] && s_q.chanPanel) begin
			s_d.running = 1'b0; // RULE_16
		end else if (press[KEY_RUN] && s_q.chanPanel) begin
			s_d.running = 1'b1; // RULE_15
		end
		if (press[KEY_SHIFT] && s_q.running) begin
			s_d.slot = (s_q.slot == 3'(MONITOR_SLOTS - 1)) ? 3'h0 : s_q.slot + 3'h1; // RULE_17 RULE_19
		end

		// Frequency ramp towards setpoint while running, towards zero after stop
		if (s_q.rampCnt == 12'(RAMP_CYCLES - 1)) begin
			s_d.rampCnt = '0;
			if (s_q.running && s_q.runFreq < s_q.setpoint) begin
				s_d.runFreq = s_q.runFreq + 16'h0001; // RULE_15
			end else if (s_q.runFreq > (s_q.running ? s_q.setpoint : 16'h0000)) begin
				s_d.runFreq = s_q.runFreq - 16'h0001; // RULE_16
			end
		end else begin
			s_d.rampCnt = s_q.rampCnt + 12'h001;
		end

		if (!s_d.running) begin
			s_d.dispCode = DISP_REF_FREQ;
		end else if (s_d.runFreq < s_d.setpoint) begin
			s_d.dispCode = DISP_RUN_FREQ; // RULE_15
		end else begin
			s_d.dispCode = s_d.monitor[s_d.slot]; // RULE_17
		end
		s_d.editing = (s_d.menu == MENU_EDIT);
		s_d.valueBlink = (s_d.menu == MENU_EDIT) &&
			editAllowed(s_d.editRo, s_d.editStop, s_d.running, s_d.password); // RULE_03
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_q <= '0;
			s_q.menu <= MENU_L2;
			s_q.bus <= BUS_IDLE;
			s_q.waitreq <= 1'b1;
			s_q.mkeyAction <= MKEY_ACTION_RST;
			s_q.runSource <= RUN_SOURCE_RST;
			s_q.setpoint <= SETPOINT_RST;
			s_q.monitor <= MONITOR_RST;
			s_q.chanPanel <= 1'b1;
			s_q.dispCode <= DISP_REF_FREQ;
		end else begin
			s_q <= s_d;
		end
	end

	assign readdata = s_q.readdata;
	assign waitrequest = s_q.waitreq;
	assign motorRun = s_q.running;
	assign reverseDir = s_q.dirReverse;
	assign forwardJog = s_q.jogFwd;
	assign reverseJog = s_q.jogRev;
	assign panelActive = s_q.chanPanel;
	assign runFrequency = s_q.runFreq;
	assign displayCode = s_q.dispCode;
	assign monitorSlot = s_q.slot;
	assign menuEditing = s_q.editing;
	assign paramIndex = s_q.paramIdx;
	assign editValue = s_q.editValue;
	assign valueBlink = s_q.valueBlink;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence seqCommit;
		s_q.menu == MENU_COMMIT ##1 s_q.menu == MENU_L2;
	endsequence

	a_enter_commit: // RULE_01
	assert property (s_q.menu == MENU_EDIT && press[KEY_ENTER] && writable |=>
		seqCommit ##0 s_q.paramIdx == $past(s_q.paramIdx, 2) + 4'h1)
		else $error("enter did not commit and advance");

	a_escape_discard: // RULE_02
	assert property (s_q.menu == MENU_EDIT && press[KEY_ESCAPE] && !press[KEY_ENTER] |=>
		s_q.menu == MENU_L2 && $stable(s_q.paramIdx) ##1 (!memBus.we || write))
		else $error("escape did not return on same parameter");

	a_blink_writable: // RULE_03
	assert property (valueBlink |-> menuEditing && !s_q.editRo && !s_q.password &&
		!(s_q.editStop && s_q.running))
		else $error("blink shown for a locked value");

	a_stop_only: // RULE_04
	assert property (s_q.menu == MENU_EDIT && s_q.editStop && s_q.running &&
		(press[KEY_UP] || press[KEY_DOWN]) |=> $stable(s_q.editValue))
		else $error("stop-only value changed while running");

	a_password_lock: // RULE_05
	assert property (s_q.password && s_q.menu == MENU_EDIT && press[KEY_ENTER] |=>
		s_q.menu == MENU_L2)
		else $error("password did not refuse commit");

	a_mkey_off: // RULE_07
	assert property (press[KEY_MULTI] && s_q.mkeyAction == 16'h0000 |=>
		$stable(s_q.dirReverse) && $stable(s_q.panelTaken) ##1 !forwardJog && !reverseJog)
		else $error("disabled key had an effect");

	a_panel_fixed: // RULE_08
	assert property (s_q.runSource == SRC_PANEL && $stable(s_q.runSource) |-> panelActive)
		else $error("panel source lost the channel");

	a_channel_toggle: // RULE_09
	assert property (press[KEY_MULTI] && mkeyCode == MKEY_CHANNEL &&
		s_q.runSource != SRC_PANEL && !(s_q.bus == BUS_IDLE && write) |=>
		panelActive != $past(panelActive))
		else $error("channel did not toggle");

	a_dir_reverse: // RULE_11
	assert property ($changed(s_q.dirReverse) |-> $past(press[KEY_MULTI] &&
		mkeyCode == MKEY_DIR && s_q.chanPanel))
		else $error("direction changed without cause");

	a_jog_panel: // RULE_12
	assert property (forwardJog || reverseJog |-> $past(s_q.chanPanel && s_q.keyLevel[KEY_MULTI]))
		else $error("jog without panel channel");

	a_run_stop: // RULE_16
	assert property (press[KEY_STOP] && panelActive |=> !motorRun ##1 !motorRun)
		else $error("stop did not halt run command");

	a_shift_range: // RULE_19
	assert property (s_q.running && press[KEY_SHIFT] && s_q.slot == 3'h4 |=> s_q.slot == 3'h0)
		else $error("shift rotation exceeded five slots");

endmodule

// >>> pkg/keypad_pkg.sv
// Purpose: Shared constants and types of the keypad menu and multi-function key logic
// Assumes: 25 MHz system clock, word-indexed register bus
// Notes: Register indices are word addresses on the bus

package keypad_pkg;

	localparam int CLK_FREQ_HZ = 25000000;
	localparam int DEBOUNCE_US = 1000;
	localparam int DEBOUNCE_CYCLES = (CLK_FREQ_HZ / 1000000) * DEBOUNCE_US;
	localparam int RAMP_STEP_US = 100;
	localparam int RAMP_CYCLES = (CLK_FREQ_HZ / 1000000) * RAMP_STEP_US;

	// Register word indices
	localparam logic [11:0] RUN_SOURCE_IDX = 12'h103;
	localparam logic [11:0] SETPOINT_IDX = 12'h10a;
	localparam logic [11:0] PARAM_BASE_IDX = 12'he00;
	localparam logic [11:0] MKEY_ACTION_IDX = 12'hf00;
	localparam logic [11:0] MONITOR_BASE_IDX = 12'hf0a;
	localparam logic [11:0] CONTROL_IDX = 12'hfe0;
	localparam logic [11:0] STATUS_IDX = 12'hfe1;

	// Reset values
	localparam logic [15:0] MKEY_ACTION_RST = 16'h0000;
	localparam logic [1:0] RUN_SOURCE_RST = 2'h0;
	localparam logic [15:0] SETPOINT_RST = 16'h1388;
	localparam int MONITOR_SLOTS = 5;
	localparam logic [MONITOR_SLOTS-1:0][5:0] MONITOR_RST = {6'h08, 6'h07, 6'h06, 6'h04, 6'h05};

	// Display codes
	localparam logic [5:0] DISP_REF_FREQ = 6'h04;
	localparam logic [5:0] DISP_RUN_FREQ = 6'h05;

	// Parameter memory layout
	localparam int PARAM_DEPTH = 16;
	localparam int PARAM_AW = 4;
	localparam int PARAM_W = 18;
	localparam int PARAM_RO_BIT = 17;
	localparam int PARAM_STOP_BIT = 16;

	// Control and status fields
	localparam int CTRL_PASSWORD_BIT = 0;
	localparam int STAT_RUNNING_BIT = 16;
	localparam int STAT_REVERSE_BIT = 17;
	localparam int STAT_PANEL_BIT = 18;
	localparam int STAT_JOGF_BIT = 19;
	localparam int STAT_JOGR_BIT = 20;
	localparam int STAT_EDIT_BIT = 21;
	localparam int STAT_SLOT_LSB = 22;

	// Key positions in the key vector
	localparam int NUM_KEYS = 8;
	localparam int KEY_ENTER = 0;
	localparam int KEY_ESCAPE = 1;
	localparam int KEY_UP = 2;
	localparam int KEY_DOWN = 3;
	localparam int KEY_RUN = 4;
	localparam int KEY_STOP = 5;
	localparam int KEY_SHIFT = 6;
	localparam int KEY_MULTI = 7;

	typedef enum logic [2:0] {
		MKEY_OFF = 3'h0,
		MKEY_CHANNEL = 3'h1,
		MKEY_DIR = 3'h2,
		MKEY_FWD_JOG = 3'h3,
		MKEY_REV_JOG = 3'h4
	} mkey_e;

	typedef enum logic [1:0] {
		SRC_PANEL = 2'h0,
		SRC_TERMINAL = 2'h1,
		SRC_COMM = 2'h2
	} src_e;

	typedef enum logic [1:0] {
		MENU_L2 = 2'b00,
		MENU_FETCH = 2'b01,
		MENU_EDIT = 2'b11,
		MENU_COMMIT = 2'b10
	} menu_e;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_MEM = 2'b01,
		BUS_DONE = 2'b11
	} bus_e;

endpackage

// >>> pkg/param_mem_if.sv
// Purpose: Port of the parameter store
// Assumes: One access per cycle, read data one cycle later
// Notes: None

`timescale 1ns/1ps

interface param_mem_if;
	import keypad_pkg::*;
	logic en;
	logic we;
	logic [PARAM_AW-1:0] addr;
	logic [PARAM_W-1:0] wdata;
	logic [PARAM_W-1:0] rdata;
	modport ctrl (output en, output we, output addr, output wdata, input rdata);
	modport store (input en, input we, input addr, input wdata, output rdata);
endinterface

// >>> hdl/param_mem.sv
// Purpose: Store of editable parameters with their lock attributes
// Assumes: Single port, registered read data
// Notes: Cleared by reset

`timescale 1ns/1ps

module param_mem
	import keypad_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	param_mem_if.store port
);

	typedef struct packed {
		logic [PARAM_DEPTH-1:0][PARAM_W-1:0] cells;
		logic [PARAM_W-1:0] rdata;
	} mem_s;

	mem_s s_q;
	mem_s s_d;

	always_comb begin
		s_d = s_q;
		if (port.en) begin
			if (port.we) begin
				s_d.cells[port.addr] = port.wdata;
			end
			s_d.rdata = s_q.cells[port.addr];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign port.rdata = s_q.rdata;

endmodule

// >>> testbench/key_operator.sv
// Purpose: Operator at the front panel, pressing one key at a time
// Assumes: A request pulse names the key; the key is held, then released
// Notes: Both hold and release last HOLD cycles, well beyond the debounce span

`timescale 1ns/1ps

module key_operator #(
	parameter int HOLD = 24
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic go,
	input wire logic [2:0] which,
	output logic [7:0] keys,
	output logic busy
);
	logic [7:0] cnt;

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt <= 8'h00;
			keys <= 8'h00;
		end else if (go && cnt == 8'h00) begin
			cnt <= 8'(2 * HOLD);
			keys <= 8'h01 << which;
		end else if (cnt != 8'h00) begin
			cnt <= cnt - 8'h01;
			if (cnt == 8'(HOLD)) begin
				keys <= 8'h00;
			end
		end
	end

	assign busy = (cnt != 8'h00);
endmodule

// >>> testbench/tb.sv
// Purpose: Self-checking bench of the keypad menu block
// Assumes: Debounce shortened to 4 cycles, operator model drives the keys
// Notes: Setpoint lowered to 3 so that ramps stay short

`timescale 1ns/1ps

`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin numErrors++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end

module tb;
	import keypad_pkg::*;
	localparam int HOLD = 24;
	localparam logic [43:0] REGS [10] = '{{12'h103, 32'h0}, {12'h10a, 32'h1388},
		{12'hf00, 32'h0}, {12'hf0a, 32'h5}, {12'hf0b, 32'h4}, {12'hf0c, 32'h6},
		{12'hf0d, 32'h7}, {12'hf0e, 32'h8}, {12'hfe0, 32'h0}, {12'h000, 32'h0}};
	// Action, run source, expected panel channel, expected reversal
	localparam logic [6:0] MROWS [9] = '{{3'h0, 2'h0, 2'b10}, {3'h1, 2'h0, 2'b10},
		{3'h1, 2'h1, 2'b10}, {3'h1, 2'h1, 2'b00}, {3'h2, 2'h1, 2'b00}, {3'h1, 2'h2, 2'b10},
		{3'h1, 2'h2, 2'b00}, {3'h2, 2'h0, 2'b11}, {3'h2, 2'h0, 2'b10}};
	localparam logic [5:0] MON [5] = '{6'h0a, 6'h04, 6'h06, 6'h07, 6'h08};
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic go = 1'b0;
	logic [2:0] keySel = 3'h0;
	logic [11:0] address = 12'h000;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [7:0] keys;
	logic busy, waitrequest, motorRun, reverseDir, forwardJog, reverseJog;
	logic panelActive, menuEditing, valueBlink;
	logic [31:0] readdata, rd;
	logic [15:0] runFrequency, editValue;
	logic [5:0] displayCode;
	logic [2:0] monitorSlot;
	logic [3:0] paramIndex;
	int numErrors = 0;
	int checked = 0;

	always #20 clk = ~clk;

	key_operator #(.HOLD(HOLD)) op_u (.clk(clk), .reset(reset), .go(go), .which(keySel),
		.keys(keys), .busy(busy));

	keypad_menu #(.DEBOUNCE_CYC(4)) dut_u (.clk(clk), .reset(reset),
		.enterKey(keys[KEY_ENTER]), .menuEscapeKey(keys[KEY_ESCAPE]), .upKey(keys[KEY_UP]),
		.downKey(keys[KEY_DOWN]), .runKey(keys[KEY_RUN]), .stopKey(keys[KEY_STOP]),
		.shiftKey(keys[KEY_SHIFT]), .multiKey(keys[KEY_MULTI]), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(4'hf),
		.readdata(readdata), .waitrequest(waitrequest), .motorRun(motorRun),
		.reverseDir(reverseDir), .forwardJog(forwardJog), .reverseJog(reverseJog),
		.panelActive(panelActive), .runFrequency(runFrequency), .displayCode(displayCode),
		.monitorSlot(monitorSlot), .menuEditing(menuEditing), .paramIndex(paramIndex),
		.editValue(editValue), .valueBlink(valueBlink));

	task automatic stop_test;
		$display("Mismatches %0d, comparisons %0d", numErrors, checked);
		if (numErrors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// One Avalon access; held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		read <= ~wr;
		write <= wr;
		address <= a;
		writedata <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 100);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		`CHK("bus answer", 1'b0, waitrequest)
	endtask

	task automatic startKey(input int k);
		@(posedge clk);
		go <= 1'b1;
		keySel <= 3'(k);
		@(posedge clk);
		go <= 1'b0;
	endtask

	task automatic pressKey(input int k);
		startKey(k);
		repeat (2 * HOLD + 4) @(posedge clk);
	endtask

	task automatic waitFreq(input logic [15:0] f);
		int n;
		n = 0;
		while (runFrequency !== f && n < 10000) begin
			@(posedge clk);
			n++;
		end
		repeat (3) @(posedge clk);
		`CHK("ramp end", f, runFrequency)
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		numErrors++;
		stop_test();
	end

	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		`CHK("panel rst", 1'b1, panelActive)
		`CHK("disp rst", DISP_REF_FREQ, displayCode)
		for (int i = 0; i < 10; i++) begin
			bus(1'b0, REGS[i][43:32], 32'h0);
			`CHK("reg reset", REGS[i][31:0], rd)
		end
		bus(1'b1, RUN_SOURCE_IDX, 32'h1);
		bus(1'b1, RUN_SOURCE_IDX, 32'h3);
		bus(1'b0, RUN_SOURCE_IDX, 32'h0);
		`CHK("src 3 ignored", 32'h1, rd)
		bus(1'b1, 12'he00, 32'h00010);
		bus(1'b1, 12'he01, 32'h20022);
		bus(1'b1, 12'he02, 32'h10033);
		pressKey(KEY_ENTER);
		`CHK("edit", 1'b1, menuEditing)
		`CHK("blink", 1'b1, valueBlink)
		pressKey(KEY_UP);
		`CHK("edit up", 16'h0011, editValue)
		pressKey(KEY_ENTER);
		`CHK("back to list", 1'b0, menuEditing)
		`CHK("next index", 4'h1, paramIndex)
		bus(1'b0, 12'he00, 32'h0);
		`CHK("stored", 32'h00000011, rd)
		pressKey(KEY_ENTER);
		`CHK("ro steady", 1'b0, valueBlink)
		pressKey(KEY_UP);
		`CHK("ro value", 16'h0022, editValue)
		pressKey(KEY_ESCAPE);
		`CHK("esc index", 4'h1, paramIndex)
		pressKey(KEY_DOWN);
		pressKey(KEY_ENTER);
		pressKey(KEY_UP);
		pressKey(KEY_ESCAPE);
		`CHK("esc list", 1'b0, menuEditing)
		bus(1'b0, 12'he00, 32'h0);
		`CHK("discarded", 32'h00000011, rd)
		bus(1'b1, CONTROL_IDX, 32'h1);
		pressKey(KEY_ENTER);
		`CHK("pw steady", 1'b0, valueBlink)
		pressKey(KEY_ESCAPE);
		bus(1'b1, CONTROL_IDX, 32'h0);
		for (int i = 0; i < 9; i++) begin
			bus(1'b1, MKEY_ACTION_IDX, {29'h0, MROWS[i][6:4]});
			bus(1'b1, RUN_SOURCE_IDX, {30'h0, MROWS[i][3:2]});
			pressKey(KEY_MULTI);
			`CHK("channel", MROWS[i][1], panelActive)
			`CHK("reversal", MROWS[i][0], reverseDir)
		end
		for (int j = 0; j < 2; j++) begin
			bus(1'b1, MKEY_ACTION_IDX, 32'(3 + j));
			startKey(KEY_MULTI);
			repeat (20) @(posedge clk);
			`CHK("jog held", 2'(1 << j), {reverseJog, forwardJog})
			repeat (2 * HOLD) @(posedge clk);
			`CHK("jog off", 2'b00, {reverseJog, forwardJog})
		end
		bus(1'b1, MKEY_ACTION_IDX, 32'h2);
		bus(1'b1, SETPOINT_IDX, 32'h3);
		bus(1'b1, MONITOR_BASE_IDX, 32'h0a);
		pressKey(KEY_UP);
		pressKey(KEY_UP);
		pressKey(KEY_RUN);
		`CHK("running", 1'b1, motorRun)
		`CHK("accel disp", DISP_RUN_FREQ, displayCode)
		waitFreq(16'h0003);
		`CHK("steady disp", MON[0], displayCode)
		pressKey(KEY_MULTI);
		`CHK("rev running", 1'b1, reverseDir)
		pressKey(KEY_ENTER);
		`CHK("stop-only run", 1'b0, valueBlink)
		pressKey(KEY_ESCAPE);
		for (int i = 1; i <= 5; i++) begin
			pressKey(KEY_SHIFT);
			`CHK("slot", 3'(i % 5), monitorSlot)
			`CHK("slot disp", MON[i % 5], displayCode)
		end
		pressKey(KEY_STOP);
		waitFreq(16'h0000);
		`CHK("stopped", 1'b0, motorRun)
		`CHK("stop disp", DISP_REF_FREQ, displayCode)
		pressKey(KEY_ENTER);
		`CHK("stop-only idle", 1'b1, valueBlink)
		pressKey(KEY_ESCAPE);
		// Reset after the stop brings state and registers back to their reset values
		@(posedge clk);
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		`CHK("dir rst", 1'b0, reverseDir)
		`CHK("index rst", 4'h0, paramIndex)
		bus(1'b0, SETPOINT_IDX, 32'h0);
		`CHK("setpoint rst", 32'h00001388, rd)
		bus(1'b0, MKEY_ACTION_IDX, 32'h0);
		`CHK("action rst", 32'h00000000, rd)
		stop_test();
	end
endmodule
